// [hdl/tfs_pkg.sv]
// Purpose: Shared constants and types for the framing select block
// Assumes: 32-bit Avalon-MM register bus, byte addresses
// Notes:   Register offsets are word indices; byte address is index * 4
package tfs_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int          AVS_ADDR_W        = 8;
    localparam int          AVS_DATA_W        = 32;
    localparam int          REG_IDX_W         = 6;
    localparam logic [5:0]  REG_IDX_CTRL      = 6'h00;
    localparam logic [5:0]  REG_IDX_STATUS    = 6'h01;
    localparam logic [5:0]  REG_IDX_FRAMING   = 6'h07;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0]  CTRL_RESET        = 8'h00;
    localparam logic [7:0]  FRAMING_RESET     = 8'h08;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int          CTRL_E1_MODE_BIT  = 0;
    localparam int          T1_FMT_LSB        = 0;
    localparam int          T1_FMT_MSB        = 2;
    localparam int          E1_IWD_EN_BIT     = 7;
    localparam int          E1_CRC_INS_BIT    = 6;
    localparam int          E1_CAS_LSB        = 4;
    localparam int          E1_CAS_MSB        = 5;
    localparam int          E1_CRC4_LSB       = 2;
    localparam int          E1_CRC4_MSB       = 3;
    localparam int          E1_FAS_CHK_BIT    = 1;
    localparam int          E1_FAS_SEL_BIT    = 0;
    localparam int          ST_E1_MODE_BIT    = 0;
    localparam int          ST_FMT_LSB        = 1;
    localparam int          ST_FMT_MSB        = 5;
    localparam int          ST_CRC_PEND_BIT   = 6;
    localparam int          ST_CAS_ACT_BIT    = 7;
    localparam int          ST_CRC_CNT_LSB    = 8;
    localparam int          ST_CRC_CNT_MSB    = 15;
    localparam int          ST_RESYNC_LSB     = 16;
    localparam int          ST_RESYNC_MSB     = 23;

    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    localparam logic [2:0]  FMT_CODE_LOOP_CARRIER = 3'h4;
    localparam logic [2:0]  FMT_CODE_SUPER    = 3'h5;
    localparam logic [2:0]  FMT_CODE_N        = 3'h6;
    localparam logic [2:0]  FMT_CODE_DM       = 3'h7;
    localparam logic [1:0]  CAS_CODE_OFF_LO   = 2'h0;
    localparam logic [1:0]  CAS_CODE_ALG1     = 2'h1;
    localparam logic [1:0]  CAS_CODE_ALG2     = 2'h2;
    localparam logic [1:0]  CAS_CODE_OFF_HI   = 2'h3;

    // Decoded T1 framing format, one-hot
    typedef enum logic [4:0] {
        TFS_FMT_EXT_SUPER    = 5'h01,
        TFS_FMT_LOOP_CARRIER = 5'h02,
        TFS_FMT_SUPER        = 5'h04,
        TFS_FMT_N            = 5'h08,
        TFS_FMT_DM           = 5'h10
    } tfs_fmt_t;

endpackage : tfs_pkg

// [hdl/tfs_pend_flag.sv]
// Purpose: Sticky request flag, set by an event, cleared when consumed
// Assumes: set and take are single-cycle pulses on clk
// Notes:   Set wins over take in the same cycle so no event is lost
`timescale 1ns/1ps
module tfs_pend_flag (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic set_pulse,
    input  wire logic take_pulse,
    output logic      pending
);
    logic pend_reg;
    logic pend_next;

    // ----------------------------------------------------------------
    // Flag update
    // ----------------------------------------------------------------
    // A second set landing on the take cycle re-arms the flag
    assign pend_next = set_pulse | (pend_reg & ~take_pulse);
    assign pending   = pend_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            pend_reg <= 1'b0;
        end else begin
            pend_reg <= pend_next;
        end
    end

endmodule : tfs_pend_flag

// [hdl/tfs_framing_select.sv]
// Contract
// - T1 format field: top bit clear is extended superframe; 1xx others.
// - E1 register fields from bit 7 down; reset value sets bit 3 only.
// - Bit 7 set enables CRC to non-CRC interworking detection.
// - A zero-to-one of bit 6 in E1 mode inverts one outgoing CRC bit; rises before that slot merge.
// - CAS select 00/11 off with no sync pulse; 01 algorithm 1; 10 algo 2.
//
// Purpose: Per-channel framing select register and its decoded controls
// Assumes: Framing engines run on clk; tx_crc_slot marks each CRC bit
// Notes:   One wait cycle on every bus access; readdata is registered
`timescale 1ns/1ps
module tfs_framing_select
    import tfs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             e1_mode,
    output tfs_fmt_t         t1_format,
    output logic             rx_resync,
    output logic             interworking_detect_en,
    output logic      [1:0]  crc4_select,
    output logic             fas_check_en,
    output logic             fas_select,
    output logic             cas_search_en,
    output logic             cas_search_alg2,
    input  wire logic        tx_crc_slot,
    output logic             tx_crc_invert,
    input  wire logic        rx_cas_sync_raw,
    output logic             cas_multiframe_sync_pulse
);

    // ----------------------------------------------------------------
    // Overview
    // ----------------------------------------------------------------
    // The framing byte is stored once; the mode bit decides whether the
    // framing engines read it as a T1 format code or as E1 controls.
    // Level outputs follow the registers directly, except t1_format, one cycle later; resync, CRC invert
    // and the sync pulse are single-cycle strobes.
    // Nothing here crosses a clock: both engines are assumed on clk.

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [7:0]  ctrl_reg;
    logic [7:0]  ctrl_next;
    logic [7:0]  framing_reg;
    logic [7:0]  framing_next;
    logic        ack_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    tfs_fmt_t    fmt_reg;
    tfs_fmt_t    fmt_next;
    logic        resync_reg;
    logic        resync_next;
    logic        crc_ins_prev_reg;
    logic [7:0]  crc_cnt_reg;
    logic [7:0]  crc_cnt_next;
    logic [7:0]  resync_cnt_reg;
    logic [7:0]  resync_cnt_next;
    logic        cas_pulse_reg;
    logic        cas_pulse_next;
    logic        tx_crc_pending;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    wire         bus_req;
    wire         wr_done;
    wire [5:0]   reg_idx;
    wire         hit_ctrl;
    wire         hit_status;
    wire         hit_framing;
    wire         lane0_en;
    wire         wr_ctrl;
    wire         wr_framing;
    wire [7:0]   wr_byte;
    wire [31:0]  status_word;

    // Register map, one byte per word in lane 0, except status, which fills bits 23:0:
    //   index 0  control, bit 0 selects E1 mode
    //   index 1  status, read only; writes to it are dropped
    //   index 7  framing select, read as T1 or E1 by the mode bit
    // Any other index reads zero and ignores writes.

    // Every access gets one wait cycle; data is ready at the release edge.
    // Waitrequest is combinational so a new request is held off at once.
    assign bus_req         = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~ack_reg;
    assign wr_done         = avs_write & ack_reg;

    // Word-aligned index; low two address bits do not select anything
    assign reg_idx     = avs_address[7:2];
    assign hit_ctrl    = (reg_idx == REG_IDX_CTRL);
    assign hit_status  = (reg_idx == REG_IDX_STATUS);
    assign hit_framing = (reg_idx == REG_IDX_FRAMING);

    // Control and framing are one byte wide and live in byte lane 0
    assign lane0_en   = avs_byteenable[0];
    assign wr_byte    = avs_writedata[7:0];
    assign wr_ctrl    = wr_done & hit_ctrl & lane0_en;
    assign wr_framing = wr_done & hit_framing & lane0_en;

    // ----------------------------------------------------------------
    // Handshake state
    // ----------------------------------------------------------------
    // Ack drops after the accepting edge so a held request is not doubled
    // A master that keeps its request up gets a fresh wait cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
        end
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // Same byte serves T1 format and E1 fields; mode picks the meaning
    assign ctrl_next    = wr_ctrl ? wr_byte : ctrl_reg;
    assign framing_next = wr_framing ? wr_byte : framing_reg;

    // Reset loads the documented default; only bit 3 comes up set
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_reg    <= CTRL_RESET;
            framing_reg <= FRAMING_RESET;
        end else begin
            ctrl_reg    <= ctrl_next;
            framing_reg <= framing_next;
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Status packs mode, decoded format, CRC and CAS activity, counters.
    // Placed field by field so the map follows the package positions.
    assign status_word[ST_E1_MODE_BIT]                = e1_mode;
    assign status_word[ST_FMT_MSB:ST_FMT_LSB]         = fmt_reg;
    assign status_word[ST_CRC_PEND_BIT]               = tx_crc_pending;
    assign status_word[ST_CAS_ACT_BIT]                = cas_search_en;
    assign status_word[ST_CRC_CNT_MSB:ST_CRC_CNT_LSB] = crc_cnt_reg;
    assign status_word[ST_RESYNC_MSB:ST_RESYNC_LSB]   = resync_cnt_reg;
    assign status_word[31:24]                         = 8'h00;

    // Sampled on the wait cycle so it stands at the release edge
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (hit_ctrl) begin
            rdata_next = {24'h00_0000, ctrl_reg};
        end else if (hit_status) begin
            rdata_next = status_word;
        end else if (hit_framing) begin
            rdata_next = {24'h00_0000, framing_reg};
        end
    end

    // Unmapped reads return zero; idle cycles clear the word
    // Clearing on idle keeps stale data off the bus between reads
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (avs_read & ~ack_reg) begin
            rdata_reg <= rdata_next;
        end else if (~bus_req) begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    assign avs_readdata = rdata_reg;

    // ----------------------------------------------------------------
    // Mode and E1 field outputs
    // ----------------------------------------------------------------
    wire [1:0]  cas_code;
    wire        e1_crc_ins_bit;

    assign e1_mode                = ctrl_reg[CTRL_E1_MODE_BIT];
    assign cas_code               = framing_reg[E1_CAS_MSB:E1_CAS_LSB];
    assign e1_crc_ins_bit         = framing_reg[E1_CRC_INS_BIT];

    // Bit 7 gates the interworking detector; zero is normal framing
    assign interworking_detect_en = e1_mode &
                                    framing_reg[E1_IWD_EN_BIT];
    // CRC-4 and FAS bits pass raw; the receive engine decodes them
    assign crc4_select            = framing_reg[E1_CRC4_MSB:E1_CRC4_LSB];
    assign fas_check_en           = framing_reg[E1_FAS_CHK_BIT];
    assign fas_select             = framing_reg[E1_FAS_SEL_BIT];

    // Both 00 and 11 leave the multiframe search off
    assign cas_search_en   = e1_mode &
                             ((cas_code == CAS_CODE_ALG1) |
                              (cas_code == CAS_CODE_ALG2));
    assign cas_search_alg2 = e1_mode &
                             (cas_code == CAS_CODE_ALG2);

    // ----------------------------------------------------------------
    // T1 format decode
    // ----------------------------------------------------------------
    wire [2:0] fmt_field;

    assign fmt_field = framing_reg[T1_FMT_MSB:T1_FMT_LSB];

    // Top bit clear always means extended superframe, whatever the rest
    always_comb begin
        case (fmt_field)
            FMT_CODE_LOOP_CARRIER: fmt_next = TFS_FMT_LOOP_CARRIER;
            FMT_CODE_SUPER:        fmt_next = TFS_FMT_SUPER;
            FMT_CODE_N:            fmt_next = TFS_FMT_N;
            FMT_CODE_DM:           fmt_next = TFS_FMT_DM;
            default:               fmt_next = TFS_FMT_EXT_SUPER;
        endcase
    end

    // A real format change, not a rewrite of the same format, resyncs.
    // Rewriting 000 as 011 keeps the format and so keeps the alignment.
    assign resync_next = ~e1_mode & (fmt_next != fmt_reg);
    // Counts wrap at 255; software should read differences, not totals
    assign resync_cnt_next = resync_reg ? resync_cnt_reg + 8'h01
                                        : resync_cnt_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            fmt_reg        <= TFS_FMT_EXT_SUPER;
            resync_reg     <= 1'b0;
            resync_cnt_reg <= 8'h00;
        end else begin
            fmt_reg        <= fmt_next;
            resync_reg     <= resync_next;
            resync_cnt_reg <= resync_cnt_next;
        end
    end

    assign t1_format = fmt_reg;
    assign rx_resync = resync_reg;

    // ----------------------------------------------------------------
    // CRC error insertion
    // ----------------------------------------------------------------
    wire  crc_ins_rise;
    wire  crc_take;

    // Only the rising edge arms a request; a held one or zero is quiet.
    // Software must clear the bit before the next rise can arm again.
    assign crc_ins_rise = e1_crc_ins_bit & ~crc_ins_prev_reg;
    assign crc_take     = tx_crc_pending & tx_crc_slot;

    always_ff @(posedge clk) begin
        if (srst) begin
            crc_ins_prev_reg <= 1'b0;
        end else begin
            crc_ins_prev_reg <= e1_crc_ins_bit;
        end
    end

    // One pending request covers exactly one CRC bit. Limitation: a second
    // rise written before the next CRC slot merges into the same request.
    tfs_pend_flag u_crc_pend (
        .clk        (clk),
        .srst       (srst),
        .set_pulse  (crc_ins_rise & e1_mode),
        .take_pulse (crc_take),
        .pending    (tx_crc_pending)
    );

    // Inversion is shown only on the consuming CRC slot
    assign tx_crc_invert = crc_take;
    assign crc_cnt_next  = crc_take ? crc_cnt_reg + 8'h01 : crc_cnt_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            crc_cnt_reg <= 8'h00;
        end else begin
            crc_cnt_reg <= crc_cnt_next;
        end
    end

    // ----------------------------------------------------------------
    // CAS multiframe sync pulse
    // ----------------------------------------------------------------
    // Registered so the pulse is a clean flop output; costs one cycle
    // While the search is off a raw pulse is dropped, never delayed
    assign cas_pulse_next = rx_cas_sync_raw & cas_search_en;

    always_ff @(posedge clk) begin
        if (srst) begin
            cas_pulse_reg <= 1'b0;
        end else begin
            cas_pulse_reg <= cas_pulse_next;
        end
    end

    assign cas_multiframe_sync_pulse = cas_pulse_reg;

endmodule : tfs_framing_select

// [testbench/tfs_framing_select_asserts.sv]
// Purpose: Port-level checks for the framing select block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ps
module tfs_framing_select_asserts
    import tfs_pkg::*;
(
    input wire logic     clk,
    input wire logic     srst,
    input wire logic     avs_read,
    input wire logic     avs_write,
    input wire logic     avs_waitrequest,
    input wire logic     e1_mode,
    input wire tfs_fmt_t t1_format,
    input wire logic     rx_resync,
    input wire logic     interworking_detect_en,
    input wire logic     cas_search_en,
    input wire logic     cas_search_alg2,
    input wire logic     tx_crc_slot,
    input wire logic     tx_crc_invert,
    input wire logic     rx_cas_sync_raw,
    input wire logic     cas_multiframe_sync_pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    // ----------------------------------------------------------------
    // Sequences
    // ----------------------------------------------------------------
    sequence s_req_held;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_cas_event;
        rx_cas_sync_raw && cas_search_en;
    endsequence

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    a_wait_first: assert property ($rose(avs_read || avs_write)
        |-> avs_waitrequest) else $error("no wait on new request");
    a_wait_one: assert property (s_req_held |=> !avs_waitrequest)
        else $error("more than one wait cycle");
    a_iwd_gated: assert property (interworking_detect_en |-> e1_mode)
        else $error("interworking detect on outside E1 mode");
    a_cas_follow: assert property (s_cas_event
        |=> cas_multiframe_sync_pulse) else $error("sync pulse missing");
    a_cas_quiet: assert property (!(rx_cas_sync_raw && cas_search_en)
        |=> !cas_multiframe_sync_pulse) else $error("sync pulse unexpected");
    a_alg_needs_en: assert property (cas_search_alg2
        |-> cas_search_en && e1_mode) else $error("alg2 without search");
    a_invert_once: assert property (tx_crc_invert
        |-> tx_crc_slot ##1 (!tx_crc_invert) [*3])
        else $error("crc invert off slot or repeated");
    a_resync_cause: assert property (rx_resync
        |-> t1_format != $past(t1_format) && !$past(e1_mode))
        else $error("resync without format change");
    a_resync_t1: assert property ((t1_format != $past(t1_format))
        && !$past(e1_mode) |-> rx_resync) else $error("resync missing");
endmodule : tfs_framing_select_asserts

bind tfs_framing_select tfs_framing_select_asserts chk_i (
    .clk(clk), .srst(srst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .e1_mode(e1_mode),
    .t1_format(t1_format), .rx_resync(rx_resync),
    .interworking_detect_en(interworking_detect_en),
    .cas_search_en(cas_search_en), .cas_search_alg2(cas_search_alg2),
    .tx_crc_slot(tx_crc_slot), .tx_crc_invert(tx_crc_invert),
    .rx_cas_sync_raw(rx_cas_sync_raw),
    .cas_multiframe_sync_pulse(cas_multiframe_sync_pulse));

// [testbench/test_tfs_framing_select.sv]
// Purpose: Self-checking bench for the framing select register block
// Assumes: One wait state per bus access, as the block answers
// Notes:   Waits on waitrequest are open; only the watchdog cuts hangs
`timescale 1ns/1ps
module test_tfs_framing_select;
    import tfs_pkg::*;
    logic        clk, srst, avs_read, avs_write, tx_crc_slot;
    logic        rx_cas_sync_raw, e1_mode, rx_resync, cas_search_en;
    logic        interworking_detect_en, fas_check_en, fas_select;
    logic        avs_waitrequest, cas_search_alg2, tx_crc_invert, cas_pulse;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd_q;
    logic [3:0]  avs_byteenable;
    logic [1:0]  crc4_select;
    tfs_fmt_t    t1_format;
    int          num_errors, tests_run, resync_seen;

    tfs_framing_select tfs_framing_select_i (
        .clk(clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .e1_mode(e1_mode), .t1_format(t1_format), .rx_resync(rx_resync),
        .interworking_detect_en(interworking_detect_en),
        .crc4_select(crc4_select), .fas_check_en(fas_check_en),
        .fas_select(fas_select), .cas_search_en(cas_search_en),
        .cas_search_alg2(cas_search_alg2), .tx_crc_slot(tx_crc_slot),
        .tx_crc_invert(tx_crc_invert), .rx_cas_sync_raw(rx_cas_sync_raw),
        .cas_multiframe_sync_pulse(cas_pulse));

    // ----------------------------------------------------------------
    // Clock, pulse counter and watchdog
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rx_resync === 1'b1) resync_seen++;
    end
    // Whole run is about 120 cycles, so 20 us is ample
    initial begin
        #20000;
        num_errors++;
        give_verdict();
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // One access; held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd_q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk); // Idle edge so strobes are never set twice at once
    endtask : bus
    task automatic rd_chk(input string name, input logic [7:0] a,
                          input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(name, exp, rd_q);
    endtask : rd_chk
    task automatic crc_slot(input logic exp);
        @(posedge clk);
        tx_crc_slot <= 1'b1;
        @(posedge clk);
        check("crc invert", {31'h0, exp}, {31'h0, tx_crc_invert});
        tx_crc_slot <= 1'b0;
    endtask : crc_slot
    function automatic tfs_fmt_t exp_fmt(input int c);
        case (c)
            4: return TFS_FMT_LOOP_CARRIER;
            5: return TFS_FMT_SUPER;
            6: return TFS_FMT_N;
            7: return TFS_FMT_DM;
            default: return TFS_FMT_EXT_SUPER;
        endcase
    endfunction : exp_fmt
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        {avs_read, avs_write, tx_crc_slot, rx_cas_sync_raw} = 4'h0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        srst = 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rd_chk("framing reset", 8'h1C, 32'h08);
        check("crc4 reset", 32'h2, {30'h0, crc4_select});
        $display("test reset done");
        // Every T1 code; codes 4..7 each change the format once
        for (int c = 0; c < 8; c++) begin
            bus(1'b1, 8'h1C, 32'(c));
            repeat (2) @(posedge clk);
            check("t1 format", {27'h0, exp_fmt(c)}, {27'h0, t1_format});
        end
        bus(1'b1, 8'h1C, 32'h03);
        repeat (2) @(posedge clk);
        check("resync count", 32'd5, 32'(resync_seen));
        bus(1'b1, 8'h3C, 32'hFF);
        rd_chk("unmapped", 8'h3C, 32'h0);
        $display("test t1 formats done");
        bus(1'b1, 8'h00, 32'h01);
        bus(1'b1, 8'h1C, 32'h80);
        rd_chk("framing rw", 8'h1C, 32'h80);
        check("iwd on", 32'h1, {31'h0, interworking_detect_en});
        bus(1'b1, 8'h1C, 32'h40);
        check("iwd off", 32'h0, {31'h0, interworking_detect_en});
        crc_slot(1'b1);
        crc_slot(1'b0);
        bus(1'b1, 8'h1C, 32'h40);
        crc_slot(1'b0);
        bus(1'b1, 8'h1C, 32'h00);
        bus(1'b1, 8'h1C, 32'h40);
        crc_slot(1'b1);
        rd_chk("ctrl rw", 8'h00, 32'h01);
        rd_chk("status", 8'h04, 32'h0005_0203);
        bus(1'b1, 8'h1C, 32'h07);
        check("crc4 sel", 32'h1, {30'h0, crc4_select});
        check("fas chk", 32'h1, {31'h0, fas_check_en});
        check("fas sel", 32'h1, {31'h0, fas_select});
        $display("test crc insert done");
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, 8'h1C, 32'(c << 4));
            check("cas en", 32'(c == 1 || c == 2),
                  {31'h0, cas_search_en});
            check("cas alg2", 32'(c == 2), {31'h0, cas_search_alg2});
            rx_cas_sync_raw <= 1'b1;
            @(posedge clk);
            rx_cas_sync_raw <= 1'b0;
            @(posedge clk);
            check("cas pulse", 32'(c == 1 || c == 2),
                  {31'h0, cas_pulse});
        end
        $display("test cas select done");
        give_verdict();
    end
endmodule : test_tfs_framing_select
